// [verilog/mrc_regs.vh]
`ifndef MRC_REGS_VH
`define MRC_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// register word indices (byte address bits 7:2)
`define MRC_CTRL            6'h00
`define MRC_STATUS          6'h01
`define MRC_IRQ_STAT        6'h02
`define MRC_IRQ_MASK        6'h03
`define MRC_PRE_DEPTH       6'h04
`define MRC_POST_DEPTH      6'h05
`define MRC_TRIG_DELAY      6'h06
`define MRC_HOLDOFF         6'h07
`define MRC_SEG_COUNT       6'h08
`define MRC_SEG_SIZE        6'h09
`define MRC_REC_DONE        6'h0A
`define MRC_MEM_ADDR        6'h0B
`define MRC_MEM_DATA        6'h0C
`define MRC_TS_LO           6'h0D
`define MRC_TS_HI           6'h0E

////////////////////////////////////////////////////////////////////////////////
// control fields
`define MRC_CTRL_START      0
`define MRC_CTRL_ABORT      1
`define MRC_CTRL_TSCLR      2
`define MRC_CTRL_VAR_LSB    4
`define MRC_CTRL_VAR_MSB    5
`define MRC_CTRL_TS_SRC     6
`define MRC_CTRL_TS_ACQ     7
`define MRC_CTRL_RSEL_LSB   8
`define MRC_CTRL_RSEL_MSB   10

`define MRC_VAR_BASIC       2'h0
`define MRC_VAR_FIXED       2'h1
`define MRC_VAR_EXT         2'h2

// interrupt bits
`define MRC_IRQ_REC         0
`define MRC_IRQ_ACQ         1
`define MRC_IRQ_IGN         2

////////////////////////////////////////////////////////////////////////////////
// timing and sizes
`define MRC_FIXED_PRE       11'h014
`define MRC_REARM_24        16'h0018
`define MRC_REARM_16        16'h0010
`define MRC_REARM_5         16'h0005
`define MRC_REARM_9         16'h0009
`define MRC_REARM_18        16'h0012
`define MRC_CLK_NS          5
`define MRC_REARM_EXT_NS    2100
`define MRC_REARM_EXT_CYC   ((`MRC_REARM_EXT_NS / `MRC_CLK_NS) - 1)
`define MRC_REARM_FEW       16'h0003
`define MRC_LONG_REC        17'h04000
`define MRC_FOOT_LAST       17'h00002

////////////////////////////////////////////////////////////////////////////////
// reset values
`define MRC_CTRL_RST        11'h000
`define MRC_MASK_RST        3'h0
`define MRC_PRE_RST         11'h000
`define MRC_POST_RST        16'h0040
`define MRC_DELAY_RST       16'h0000
`define MRC_HOLD_RST        16'h0000
`define MRC_SEGCNT_RST      16'h0004
`define MRC_SEGSZ_RST       12'h080

`endif

// [verilog/mrc_pretrig_delay.v]
`timescale 1ns/100ps
`include "mrc_regs.vh"

module mrc_pretrig_delay (
    // system
    input  wire        clk_i,
    input  wire        rst_i,
    // stream
    input  wire [15:0] din_i,
    input  wire [10:0] dly_i,
    output reg  [15:0] dout_o
);

    reg  [15:0] ring [0:2047];
    reg  [10:0] wp_reg;
    wire [10:0] rp;

    assign rp = wp_reg - dly_i;

    ////////////////////////////////////////////////////////////////////////////
    // ring of history, output delayed dly_i + 1 cycles
    always @(posedge clk_i) begin
        ring[wp_reg] <= din_i;
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wp_reg <= 11'h000;
            dout_o <= 16'h0000;
        end else begin
            wp_reg <= wp_reg + 11'h001;
            if (dly_i == 11'h000) begin
                dout_o <= din_i;
            end else begin
                dout_o <= ring[rp];
            end
        end
    end

endmodule

// [verilog/mrc_capture.v]
// The implementer's own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
`include "mrc_regs.vh"

module mrc_capture (
    // system
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // sample stream and trigger
    input  wire [15:0] adc_data_i,
    input  wire        trig_i,
    input  wire        ref_clk_i,
    // status
    output reg         irq_o,
    output reg         busy_o,
    output reg         done_o
);

    localparam [2:0]  ST_IDLE  = 3'h0;
    localparam [2:0]  ST_REARM = 3'h1;
    localparam [2:0]  ST_ARMED = 3'h2;
    localparam [2:0]  ST_DELAY = 3'h3;
    localparam [2:0]  ST_CAPT  = 3'h4;
    localparam [15:0] REARM_EXT = `MRC_REARM_EXT_CYC;

    ////////////////////////////////////////////////////////////////////////////
    // functions
    function [31:0] wmerge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  sel;
        integer      i;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                wmerge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
            end
        end
    endfunction

    function [10:0] pre_sel;
        input [1:0]  vrt;
        input [10:0] pre;
        begin
            case (vrt)
                `MRC_VAR_FIXED: pre_sel = `MRC_FIXED_PRE;
                `MRC_VAR_EXT:   pre_sel = pre;
                default:        pre_sel = 11'h000;
            endcase
        end
    endfunction

    function [15:0] rearm_len;
        input [1:0]  vrt;
        input [2:0]  rsel;
        input [16:0] reclen;
        begin
            if (vrt == `MRC_VAR_EXT) begin
                rearm_len = (reclen > `MRC_LONG_REC) ? `MRC_REARM_FEW : REARM_EXT;
            end else begin
                case (rsel)
                    3'h0:    rearm_len = `MRC_REARM_24;
                    3'h1:    rearm_len = `MRC_REARM_16;
                    3'h2:    rearm_len = `MRC_REARM_5;
                    3'h3:    rearm_len = `MRC_REARM_9;
                    3'h4:    rearm_len = `MRC_REARM_18;
                    default: rearm_len = `MRC_REARM_5;
                endcase
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    reg  [10:0] ctrl_reg;
    reg  [2:0]  stat_reg;
    reg  [2:0]  mask_reg;
    reg  [10:0] pre_reg;
    reg  [15:0] post_reg;
    reg  [15:0] delay_reg;
    reg  [15:0] hold_reg;
    reg  [15:0] segcnt_reg;
    reg  [11:0] segsz_reg;
    reg  [11:0] maddr_reg;
    reg  [15:0] mem_q_reg;
    reg  [15:0] mem [0:4095];

    reg  [2:0]  state_reg;
    reg  [16:0] cnt_reg;
    reg  [16:0] idx_reg;
    reg  [15:0] rec_reg;
    reg  [11:0] base_reg;
    reg  [43:0] ts_reg;
    reg  [43:0] tslat_reg;

    reg         ref_meta_reg;
    reg         ref_s1_reg;
    reg         ref_s2_reg;

    reg  [31:0] rd_val;
    reg  [15:0] foot_word;

    wire [5:0]  reg_sel;
    wire        req;
    wire        wr_go;
    wire        rd_go;
    wire        cmd_start;
    wire        cmd_abort;
    wire        cmd_tsclr;
    wire [1:0]  vrt;
    wire [31:0] wr_m;
    wire        ts_src;
    wire        ts_acq;
    wire [2:0]  rsel;
    wire [10:0] pre_eff;
    wire [16:0] rec_sum;
    wire [16:0] rec_len;
    wire [15:0] rearm_n;
    wire [15:0] dly_out;
    wire        ref_tick;
    wire        start_go;
    wire        cap_end;
    wire        in_foot;
    wire        ev_rec;
    wire        ev_acq;
    wire        ev_ign;
    wire [2:0]  ev_all;
    wire [16:0] foot_idx;
    wire [11:0] mem_wa;
    wire [15:0] mem_wd;

    ////////////////////////////////////////////////////////////////////////////
    // decode
    assign reg_sel   = wb_adr_i[7:2];
    assign req       = wb_cyc_i & wb_stb_i;
    assign wr_go     = req & wb_we_i & wb_ack_o;
    assign rd_go     = req & ~wb_we_i & wb_ack_o;
    assign wr_m      = wmerge(rd_val, wb_dat_i, wb_sel_i);
    assign cmd_start = wr_go & (reg_sel == `MRC_CTRL) & wb_sel_i[0] & wb_dat_i[`MRC_CTRL_START];
    assign cmd_abort = wr_go & (reg_sel == `MRC_CTRL) & wb_sel_i[0] & wb_dat_i[`MRC_CTRL_ABORT];
    assign cmd_tsclr = wr_go & (reg_sel == `MRC_CTRL) & wb_sel_i[0] & wb_dat_i[`MRC_CTRL_TSCLR];

    assign vrt     = ctrl_reg[`MRC_CTRL_VAR_MSB:`MRC_CTRL_VAR_LSB];
    assign ts_src  = ctrl_reg[`MRC_CTRL_TS_SRC];
    assign ts_acq  = ctrl_reg[`MRC_CTRL_TS_ACQ];
    assign rsel    = ctrl_reg[`MRC_CTRL_RSEL_MSB:`MRC_CTRL_RSEL_LSB];
    assign pre_eff = pre_sel(vrt, pre_reg);
    assign rec_sum = {6'h00, pre_eff} + {1'b0, post_reg};
    assign rec_len = (rec_sum == 17'h00000) ? 17'h00001 : rec_sum;
    assign rearm_n = rearm_len(vrt, rsel, rec_len);

    ////////////////////////////////////////////////////////////////////////////
    // pre-trigger history
    mrc_pretrig_delay u_dly (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .din_i  (adc_data_i),
        .dly_i  (pre_eff),
        .dout_o (dly_out)
    );

    ////////////////////////////////////////////////////////////////////////////
    // capture control
    assign start_go = cmd_start & (state_reg == ST_IDLE);
    assign in_foot  = idx_reg >= rec_len;
    assign foot_idx = idx_reg - rec_len;
    assign cap_end  = (state_reg == ST_CAPT) & (foot_idx == `MRC_FOOT_LAST) & in_foot;
    assign ev_rec   = cap_end;
    assign ev_acq   = cap_end & ((rec_reg + 16'h0001) >= segcnt_reg);
    assign ev_ign   = trig_i & (state_reg != ST_IDLE) & (state_reg != ST_ARMED);
    assign ev_all   = {ev_ign, ev_acq, ev_rec};

    always @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= 17'h00000;
            idx_reg   <= 17'h00000;
            rec_reg   <= 16'h0000;
            base_reg  <= 12'h000;
            tslat_reg <= 44'h00000000000;
        end else if (cmd_abort) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (start_go) begin
                        state_reg <= ST_REARM;
                        cnt_reg   <= {1'b0, hold_reg};
                        rec_reg   <= 16'h0000;
                        base_reg  <= 12'h000;
                    end
                end
                ST_REARM: begin
                    if (cnt_reg == 17'h00000) begin
                        state_reg <= ST_ARMED;
                    end else begin
                        cnt_reg <= cnt_reg - 17'h00001;
                    end
                end
                ST_ARMED: begin
                    if (trig_i) begin
                        tslat_reg <= ts_reg;
                        idx_reg   <= 17'h00000;
                        if (delay_reg == 16'h0000) begin
                            state_reg <= ST_CAPT;
                        end else begin
                            state_reg <= ST_DELAY;
                            cnt_reg   <= {1'b0, delay_reg} - 17'h00001;
                        end
                    end
                end
                ST_DELAY: begin
                    if (cnt_reg == 17'h00000) begin
                        state_reg <= ST_CAPT;
                    end else begin
                        cnt_reg <= cnt_reg - 17'h00001;
                    end
                end
                ST_CAPT: begin
                    idx_reg <= idx_reg + 17'h00001;
                    if (cap_end) begin
                        rec_reg  <= rec_reg + 16'h0001;
                        base_reg <= base_reg + segsz_reg;
                        idx_reg  <= 17'h00000;
                        if (ev_acq) begin
                            state_reg <= ST_IDLE;
                        end else begin
                            state_reg <= ST_REARM;
                            cnt_reg   <= {1'b0, rearm_n} + {1'b0, hold_reg} - 17'h00001;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sample memory
    always @* begin
        case (foot_idx[1:0])
            2'h0:    foot_word = tslat_reg[15:0];
            2'h1:    foot_word = tslat_reg[31:16];
            default: foot_word = {4'h0, tslat_reg[43:32]};
        endcase
    end

    assign mem_wa = base_reg + idx_reg[11:0];
    assign mem_wd = in_foot ? foot_word : dly_out;

    always @(posedge clk_i) begin
        if (state_reg == ST_CAPT) begin
            mem[mem_wa] <= mem_wd;
        end
        mem_q_reg <= mem[maddr_reg];
    end

    ////////////////////////////////////////////////////////////////////////////
    // time-stamp counter
    assign ref_tick = ref_s1_reg & ~ref_s2_reg;

    always @(posedge clk_i) begin
        if (rst_i) begin
            ref_meta_reg <= 1'b0;
            ref_s1_reg   <= 1'b0;
            ref_s2_reg   <= 1'b0;
            ts_reg       <= 44'h00000000000;
        end else begin
            ref_meta_reg <= ref_clk_i;
            ref_s1_reg   <= ref_meta_reg;
            ref_s2_reg   <= ref_s1_reg;
            if (cmd_tsclr) begin
                ts_reg <= 44'h00000000000;
            end else if (start_go & ts_acq) begin
                ts_reg <= 44'h00000000000;
            end else if (ts_src ? ref_tick : 1'b1) begin
                ts_reg <= ts_reg + 44'h00000000001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register writes and interrupts
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg   <= `MRC_CTRL_RST;
            mask_reg   <= `MRC_MASK_RST;
            stat_reg   <= 3'h0;
            pre_reg    <= `MRC_PRE_RST;
            post_reg   <= `MRC_POST_RST;
            delay_reg  <= `MRC_DELAY_RST;
            hold_reg   <= `MRC_HOLD_RST;
            segcnt_reg <= `MRC_SEGCNT_RST;
            segsz_reg  <= `MRC_SEGSZ_RST;
            maddr_reg  <= 12'h000;
            irq_o      <= 1'b0;
            busy_o     <= 1'b0;
            done_o     <= 1'b0;
        end else begin
            if (wr_go) begin
                case (reg_sel)
                    `MRC_CTRL:       ctrl_reg   <= wr_m[10:0];
                    `MRC_IRQ_MASK:   mask_reg   <= wr_m[2:0];
                    `MRC_PRE_DEPTH:  pre_reg    <= wr_m[10:0];
                    `MRC_POST_DEPTH: post_reg   <= wr_m[15:0];
                    `MRC_TRIG_DELAY: delay_reg  <= wr_m[15:0];
                    `MRC_HOLDOFF:    hold_reg   <= wr_m[15:0];
                    `MRC_SEG_COUNT:  segcnt_reg <= wr_m[15:0];
                    `MRC_SEG_SIZE:   segsz_reg  <= wr_m[11:0];
                    `MRC_MEM_ADDR:   maddr_reg  <= wr_m[11:0];
                    default: begin
                    end
                endcase
            end else if (rd_go & (reg_sel == `MRC_MEM_DATA)) begin
                maddr_reg <= maddr_reg + 12'h001;
            end
            if (wr_go & (reg_sel == `MRC_IRQ_STAT) & wb_sel_i[0]) begin
                stat_reg <= (stat_reg & ~wb_dat_i[2:0]) | ev_all;
            end else begin
                stat_reg <= stat_reg | ev_all;
            end
            irq_o  <= |(stat_reg & mask_reg);
            busy_o <= (state_reg != ST_IDLE);
            if (ev_acq) begin
                done_o <= 1'b1;
            end else if (start_go) begin
                done_o <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wishbone read and ack
    always @* begin
        rd_val = 32'h00000000;
        case (reg_sel)
            `MRC_CTRL:       rd_val = {21'h000000, ctrl_reg};
            `MRC_STATUS:     rd_val = {26'h0000000, state_reg, done_o, state_reg == ST_ARMED, busy_o};
            `MRC_IRQ_STAT:   rd_val = {29'h00000000, stat_reg};
            `MRC_IRQ_MASK:   rd_val = {29'h00000000, mask_reg};
            `MRC_PRE_DEPTH:  rd_val = {21'h000000, pre_reg};
            `MRC_POST_DEPTH: rd_val = {16'h0000, post_reg};
            `MRC_TRIG_DELAY: rd_val = {16'h0000, delay_reg};
            `MRC_HOLDOFF:    rd_val = {16'h0000, hold_reg};
            `MRC_SEG_COUNT:  rd_val = {16'h0000, segcnt_reg};
            `MRC_SEG_SIZE:   rd_val = {20'h00000, segsz_reg};
            `MRC_REC_DONE:   rd_val = {16'h0000, rec_reg};
            `MRC_MEM_ADDR:   rd_val = {20'h00000, maddr_reg};
            `MRC_MEM_DATA:   rd_val = {16'h0000, mem_q_reg};
            `MRC_TS_LO:      rd_val = ts_reg[31:0];
            `MRC_TS_HI:      rd_val = {20'h00000, ts_reg[43:32]};
            default:         rd_val = 32'h00000000;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
            if (req & ~wb_ack_o & ~wb_we_i) begin
                wb_dat_o <= rd_val;
            end
        end
    end

endmodule

// [test/mrc_capture_monitor.sv]
`timescale 1ns/100ps
module mrc_capture_chk (
    // system
    input wire        clk_i,
    input wire        rst_i,
    // wishbone
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [7:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    // status
    input wire        irq_o,
    input wire        busy_o,
    input wire        done_o
);
    wire req = wb_cyc_i & wb_stb_i;
    wire ctl = wb_ack_o & wb_we_i & (wb_adr_i[7:2] == 6'h00) & wb_sel_i[0];
    wire go  = ctl & wb_dat_i[0];
    wire ab  = ctl & wb_dat_i[1];
    wire unm = req & ~wb_we_i & ~wb_ack_o & (wb_adr_i[7:2] > 6'h0E);

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ack_answer: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_idle: assert property (!req |=> !wb_ack_o)
        else $error("ack without request");
    a_unmapped_zero: assert property (unm |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !irq_o && !busy_o && !done_o && !wb_ack_o)
        else $error("outputs active in reset");
    a_start_runs: assert property (go && !busy_o |-> ##[1:2] busy_o)
        else $error("start did not run");
    a_busy_cause: assert property ($rose(busy_o) |-> $past(go, 1) || $past(go, 2))
        else $error("busy without start");
    a_busy_end: assert property ($fell(busy_o) && !$past(ab, 1) && !$past(ab, 2) |-> ##[0:2] done_o)
        else $error("run ended without done");
    a_done_clear: assert property ($rose(busy_o) |-> ##[0:2] !done_o)
        else $error("done kept after start");
endmodule

bind mrc_capture mrc_capture_chk i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq_o(irq_o), .busy_o(busy_o), .done_o(done_o)
);

// [test/mrc_src_model.sv]
`timescale 1ns/100ps
module mrc_src_model (
    // system
    input  wire        clk_i,
    input  wire        rst_i,
    // bench control
    input  wire        fire_i,
    input  wire        hold_i,
    input  wire        ref_en_i,
    // to block
    output reg  [15:0] adc_data_o,
    output reg         trig_o,
    output reg         ref_clk_o
);
    reg [1:0] div_reg;
    ////////////////////////////////////////////////////////////////////////////
    // ramp samples, trigger, slow reference clock standing still when off
    always @(posedge clk_i) begin
        if (rst_i) begin
            adc_data_o <= 16'h0000;
            div_reg    <= 2'h0;
            ref_clk_o  <= 1'b0;
            trig_o     <= 1'b0;
        end else begin
            adc_data_o <= adc_data_o + 16'h0001;
            trig_o     <= fire_i | hold_i;
            if (ref_en_i)
                div_reg <= div_reg + 2'h1;
            ref_clk_o  <= div_reg[1];
        end
    end
endmodule

// [test/tb.sv]
`timescale 1ns/100ps
`include "mrc_regs.vh"
module tb;
    reg         clk_i, rst_i, wb_cyc, wb_stb, wb_we, fire, hold, ref_en;
    reg  [7:0]  wb_adr;
    reg  [3:0]  wb_sel;
    reg  [31:0] wb_dw, rd, bsp, sp;
    wire [31:0] wb_dr;
    wire        wb_ack, trig, refc, irq, busy, done;
    wire [15:0] adc;
    integer     err_total, tests_run, n;
    reg  [15:0] mem [0:311];

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    mrc_src_model i_src (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .hold_i(hold), .ref_en_i(ref_en),
                         .adc_data_o(adc), .trig_o(trig), .ref_clk_o(refc));
    mrc_capture i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
                       .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dw), .wb_dat_o(wb_dr),
                       .wb_ack_o(wb_ack), .adc_data_i(adc), .trig_i(trig), .ref_clk_i(refc),
                       .irq_o(irq), .busy_o(busy), .done_o(done));

    ////////////////////////////////////////////////////////////////////////////
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", tests_run, err_total);
            if (err_total == 0 && tests_run > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    task chk(input [31:0] got, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("ERROR %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task tmo;
        begin
            err_total = err_total + 1;
            $display("ERROR %0t wait ran out", $time);
            stop_test;
        end
    endtask

    // one classic cycle, entered just after a rising edge
    task wb(input w, input [5:0] r, input [31:0] d);
        begin
            wb_cyc <= 1'b1;
            wb_stb <= 1'b1;
            wb_we  <= w;
            wb_adr <= {r, 2'b00};
            wb_dw  <= d;
            wb_sel <= 4'hF;
            n = 0;
            @(posedge clk_i);
            while (wb_ack !== 1'b1 && n < 50) begin
                n = n + 1;
                @(posedge clk_i);
            end
            if (n >= 50)
                tmo;
            rd = wb_dr;
            wb_cyc <= 1'b0;
            wb_stb <= 1'b0;
            @(posedge clk_i);
        end
    endtask

    task wait_sig(input integer which, input integer lim);
        begin
            n = 0;
            while (((which == 0) ? done : irq) !== 1'b1 && n < lim) begin
                n = n + 1;
                @(posedge clk_i);
            end
            if (n >= lim)
                tmo;
        end
    endtask

    task cfg(input [10:0] pre, input [15:0] post, input [15:0] dl, input [15:0] ho, input [11:0] ss);
        begin
            wb(1, `MRC_PRE_DEPTH, pre);
            wb(1, `MRC_POST_DEPTH, post);
            wb(1, `MRC_TRIG_DELAY, dl);
            wb(1, `MRC_HOLDOFF, ho);
            wb(1, `MRC_SEG_COUNT, 32'h2);
            wb(1, `MRC_SEG_SIZE, ss);
            wb(1, `MRC_IRQ_STAT, 32'h7);
            wb(1, `MRC_IRQ_MASK, 32'h1);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task t_reset;
        begin
            wb(0, `MRC_CTRL, 0);
            chk(rd, 32'h0);
            wb(0, `MRC_POST_DEPTH, 0);
            chk(rd, 32'h40);
            wb(0, `MRC_SEG_COUNT, 0);
            chk(rd, 32'h4);
            wb(0, `MRC_SEG_SIZE, 0);
            chk(rd, 32'h80);
            wb(1, 6'h3F, 32'hFFFFFFFF);
            wb(0, 6'h3F, 0);
            chk(rd, 32'h0);
            wb(1, `MRC_CTRL, 32'h1);
            wb(0, `MRC_STATUS, 0);
            chk(rd, 32'h13);
            wb(1, `MRC_CTRL, 32'h2);
            wb(0, `MRC_STATUS, 0);
            chk(rd, 32'h0);
            $display("test reset done");
        end
    endtask

    // pulsed triggers, a stray one in each capture
    task t_window(input [1:0] v, input [10:0] wpre, input [10:0] pre);
        integer r, k, len;
        reg [15:0] tv [0:1];
        reg [15:0] e, f;
        begin
            len = pre + 8;
            cfg(wpre, 16'h8, 16'h0, 16'h0, 12'h200);
            wb(1, `MRC_CTRL, {v, 4'h0} | 32'h81);
            for (r = 0; r < 2; r = r + 1) begin
                rd = 0;
                n = 0;
                while (rd[1] !== 1'b1 && n < 600) begin
                    wb(0, `MRC_STATUS, 0);
                    n = n + 1;
                end
                if (rd[1] !== 1'b1)
                    tmo;
                fire <= 1'b1;
                @(posedge clk_i);
                fire <= 1'b0;
                @(posedge clk_i);
                chk(trig, 1'b1);
                tv[r] = adc;
                fire <= 1'b1;
                @(posedge clk_i);
                fire <= 1'b0;
            end
            wait_sig(0, 2000);
            wb(0, `MRC_REC_DONE, 0);
            chk(rd, 32'h2);
            wb(0, `MRC_IRQ_STAT, 0);
            chk(rd, 32'h7);
            chk(irq, 1'b1);
            wb(1, `MRC_IRQ_MASK, 32'h0);
            repeat (3) @(posedge clk_i);
            chk(irq, 1'b0);
            wb(1, `MRC_IRQ_STAT, 32'h7);
            wb(1, `MRC_IRQ_MASK, 32'h7);
            repeat (3) @(posedge clk_i);
            chk(irq, 1'b0);
            for (r = 0; r < 2; r = r + 1) begin
                wb(1, `MRC_MEM_ADDR, r * 32'h200);
                for (k = 0; k < len + 3; k = k + 1) begin
                    wb(0, `MRC_MEM_DATA, 0);
                    mem[k] = rd[15:0];
                end
                for (k = 0; k < len; k = k + 1) begin
                    e = tv[r] - pre + k;
                    chk(mem[k], e);
                end
                chk(mem[len + 2], 16'h0);
                e = mem[len] - f;
                f = mem[len];
            end
            chk(e, tv[1] - tv[0]);
            $display("test window done");
        end
    endtask

    task ftr(input [11:0] off, output [31:0] t);
        begin
            wb(1, `MRC_MEM_ADDR, off);
            wb(0, `MRC_MEM_DATA, 0);
            t[15:0] = rd[15:0];
            wb(0, `MRC_MEM_DATA, 0);
            t[31:16] = rd[15:0];
        end
    endtask

    // trigger held high; spacing of time-stamps gives the re-arm time
    task t_rearm(input [11:0] c, input [15:0] post, input [15:0] dl, input [15:0] ho, output [31:0] s);
        reg [31:0] a, b;
        begin
            cfg(11'h0, post, dl, ho, 12'h800);
            hold <= 1'b1;
            wb(1, `MRC_CTRL, c | 32'h81);
            wait_sig(1, 40000);
            ftr(post, a);
            wait_sig(0, 40000);
            hold <= 1'b0;
            ftr(post + 16'h800, b);
            s = b - a;
            $display("test rearm done");
        end
    endtask

    task t_ts;
        reg [31:0] a;
        begin
            wb(1, `MRC_CTRL, 32'h44);
            wb(0, `MRC_TS_LO, 0);
            chk(rd, 32'h0);
            wb(0, `MRC_TS_HI, 0);
            chk(rd, 32'h0);
            ref_en <= 1'b1;
            repeat (200) @(posedge clk_i);
            ref_en <= 1'b0;
            repeat (8) @(posedge clk_i);
            wb(0, `MRC_TS_LO, 0);
            a = rd;
            chk(a >= 48 && a <= 52, 1'b1);
            wb(0, `MRC_TS_LO, 0);
            chk(rd, a);
            $display("test timestamp done");
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        err_total = 0;
        tests_run = 0;
        rst_i = 1'b1;
        {wb_cyc, wb_stb, wb_we, fire, hold, ref_en} = 6'h00;
        wb_adr = 8'h00;
        wb_sel = 4'h0;
        wb_dw = 32'h0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset;
        t_window(2'h0, 11'h7, 11'h0);
        t_window(2'h1, 11'h7, 11'h14);
        t_window(2'h2, 11'h12C, 11'h12C);
        t_rearm(12'h200, 16'h8, 16'h0, 16'h0, bsp);
        t_rearm(12'h000, 16'h8, 16'h0, 16'h0, sp);
        chk(sp - bsp, 32'd19);
        t_rearm(12'h100, 16'h8, 16'h0, 16'h0, sp);
        chk(sp - bsp, 32'd11);
        t_rearm(12'h300, 16'h8, 16'h0, 16'h0, sp);
        chk(sp - bsp, 32'd4);
        t_rearm(12'h400, 16'h8, 16'h0, 16'h0, sp);
        chk(sp - bsp, 32'd13);
        t_rearm(12'h020, 16'h8, 16'h0, 16'h0, sp);
        chk(sp - bsp, 32'd414);
        t_rearm(12'h200, 16'h8, 16'h4, 16'h7, sp);
        chk(sp - bsp, 32'd11);
        t_rearm(12'h020, 16'h4001, 16'h0, 16'h0, sp);
        chk(sp - bsp, 32'd16375);
        t_ts;
        stop_test;
    end
endmodule
